// ---- core/ocs_top.sv ----
// accumulator select and accumulator reset control for two oscillators, AHB-Lite register slave
// assumes select, bank and trigger lines are synchronous to ref_clk; single word transfers only
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

`include "ocs_regs.svh"

module ocs_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [`OCS_EXT_SEL_W-1:0] ext_sel,
	input wire logic bank_sel,
	input wire logic trig,
	input wire logic sysref,
	output ocs_pkg::ocs_sel_t sel_a,
	output ocs_pkg::ocs_sel_t sel_b,
	output logic accum_reset
);
	import ocs_pkg::*;

	// bus state
	logic wr_pend_r;
	logic rd_pend_r;
	logic [9:0] addr_idx_r;
	logic addr_ok_r;
	logic hreadyout_r;
	logic hresp_r;
	logic [31:0] hrdata_r;

	// software registers
	logic [7:0] sync_src_reg_r;
	logic [15:0] reg_sel_r;
	logic [7:0] bank_cfg_reg_r;
	logic osc_enable_r;
	logic sw_sync_r;
	logic change_blocking_r;

	// control state
	logic arm_r;
	logic accum_reset_r;
	ocs_sel_t sel_a_r;
	ocs_sel_t sel_b_r;

	// decoded fields
	ocs_sync_src_t accum_reset_source;
	ocs_bank_cfg_t osc_bank_config;
	logic chan_a_select_source;
	logic chan_b_select_source;
	ocs_sel_t reg_sel_a;
	ocs_sel_t reg_sel_b;

	// edges and events
	logic [1:0] rise;
	logic trig_rise;
	logic sysref_rise;
	logic addr_phase;
	logic sync_start;
	logic fire_now;
	ocs_sel_t ext_sel_a;
	ocs_sel_t ext_sel_b;
	logic ext_hit_a;
	logic ext_hit_b;

	// true when a data phase write targets the given index
	function automatic logic wr_hit(input logic pend, input logic ok, input logic [9:0] idx,
		input logic [9:0] want);
		wr_hit = pend & ok & (idx == want);
	endfunction : wr_hit

	assign accum_reset_source = ocs_sync_src_t'(sync_src_reg_r[`OCS_SRC_HI:`OCS_SRC_LO]);
	assign osc_bank_config = ocs_bank_cfg_t'(bank_cfg_reg_r[`OCS_BANK_CFG_HI:`OCS_BANK_CFG_LO]);
	assign chan_a_select_source = sync_src_reg_r[`OCS_CHG_SRC_A_BIT];
	assign chan_b_select_source = sync_src_reg_r[`OCS_CHG_SRC_B_BIT];
	assign reg_sel_a = reg_sel_r[`OCS_SEL_A_HI:`OCS_SEL_A_LO];
	assign reg_sel_b = reg_sel_r[`OCS_SEL_B_HI:`OCS_SEL_B_LO];

	// edge detection on trigger and sysref
	ocs_edge_det #(
		.WIDTH(2)
	) u_edges (
		.ref_clk(ref_clk),
		.rst(rst),
		.level_in({sysref, trig}),
		.rise_out(rise)
	);
	assign trig_rise = rise[0];
	assign sysref_rise = rise[1];

	// ahb address phase accepted
	assign addr_phase = hsel & htrans[1] & hready;

	// address phase capture; reads get one wait state so data follow any prior write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_idx_r <= 10'h000;
			addr_ok_r <= 1'b0;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			rd_pend_r <= addr_phase & ~hwrite;
			if (addr_phase) begin
				addr_idx_r <= haddr[11:2];
				addr_ok_r <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
			end
		end
	end

	// ready, response and read data
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			hrdata_r <= 32'h00000000;
		end else begin
			hresp_r <= 1'b0;
			if (addr_phase & ~hwrite) begin
				hreadyout_r <= 1'b0;
			end else begin
				hreadyout_r <= 1'b1;
			end
			if (rd_pend_r) begin
				hrdata_r <= 32'h00000000;
				if (addr_ok_r) begin
					case (addr_idx_r)
						`OCS_IDX_SYNC_SRC: hrdata_r <= {24'h000000, sync_src_reg_r};
						`OCS_IDX_REG_SEL: hrdata_r <= {16'h0000, reg_sel_r};
						`OCS_IDX_BANK_CFG: hrdata_r <= {24'h000000, bank_cfg_reg_r};
						`OCS_IDX_OSC_EN: hrdata_r <= {31'h00000000, osc_enable_r};
						`OCS_IDX_SW_SYNC: hrdata_r <= {31'h00000000, sw_sync_r};
						`OCS_IDX_CHG_BLK: hrdata_r <= {31'h00000000, change_blocking_r};
						`OCS_IDX_STATUS: hrdata_r <= {14'h0000, arm_r, accum_reset_r, 3'h0, sel_b_r,
							3'h0, sel_a_r};
						default: hrdata_r <= 32'h00000000;
					endcase
				end
			end
		end
	end

	// register writes; reserved bits stored and read back as written
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_src_reg_r <= `OCS_RST_SYNC_SRC;
			reg_sel_r <= `OCS_RST_REG_SEL;
			bank_cfg_reg_r <= `OCS_RST_BANK_CFG;
			osc_enable_r <= `OCS_RST_1BIT;
			sw_sync_r <= `OCS_RST_1BIT;
			change_blocking_r <= `OCS_RST_1BIT;
		end else begin
			if (wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_SYNC_SRC)) begin
				sync_src_reg_r <= hwdata[7:0];
			end
			if (wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_REG_SEL)) begin
				reg_sel_r <= hwdata[15:0];
			end
			if (wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_BANK_CFG)) begin
				bank_cfg_reg_r <= hwdata[7:0];
			end
			if (wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_OSC_EN)) begin
				osc_enable_r <= hwdata[0];
			end
			if (wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_SW_SYNC)) begin
				sw_sync_r <= hwdata[0];
			end
			if (wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_CHG_BLK)) begin
				change_blocking_r <= hwdata[0];
			end
		end
	end

	// sync request only on a 0-to-1 write of the sync bit
	assign sync_start = wr_hit(wr_pend_r, addr_ok_r, addr_idx_r, `OCS_IDX_SW_SYNC)
		& hwdata[0] & ~sw_sync_r;

	// armed reset fires on the bound event; reserved source never fires
	always_comb begin
		fire_now = 1'b0;
		case (accum_reset_source)
			OCS_SYNC_NOW: fire_now = sync_start;
			OCS_SYNC_SYSREF: fire_now = arm_r & sysref_rise;
			OCS_SYNC_TRIG: fire_now = arm_r & trig_rise & bank_sel;
			OCS_SYNC_RSVD: fire_now = 1'b0;
			default: fire_now = 1'b0;
		endcase
	end

	// arm flag: a new request wins over the firing clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arm_r <= 1'b0;
		end else begin
			if (sync_start && (accum_reset_source == OCS_SYNC_SYSREF
				|| accum_reset_source == OCS_SYNC_TRIG)) begin
				arm_r <= 1'b1;
			end else if (fire_now || accum_reset_source == OCS_SYNC_NOW
				|| accum_reset_source == OCS_SYNC_RSVD) begin
				arm_r <= 1'b0;
			end
		end
	end

	// accumulator reset: held while disabled, pulsed when a sync fires
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			accum_reset_r <= 1'b1;
		end else begin
			accum_reset_r <= ~osc_enable_r | fire_now;
		end
	end

	// external selections per bank configuration
	always_comb begin
		ext_sel_a = {1'b0, ext_sel};
		ext_sel_b = {1'b1, ext_sel};
		ext_hit_a = 1'b0;
		ext_hit_b = 1'b0;
		case (osc_bank_config)
			OCS_BANK_SPLIT: begin
				ext_hit_a = trig_rise;
				ext_hit_b = trig_rise;
			end
			OCS_BANK_SHARED: begin
				ext_sel_a = {bank_sel, ext_sel};
				ext_sel_b = {bank_sel, ext_sel};
				ext_hit_a = trig_rise;
				ext_hit_b = trig_rise;
			end
			OCS_BANK_ONE_CHAN: begin
				ext_hit_a = trig_rise & ~bank_sel;
				ext_hit_b = trig_rise & bank_sel;
			end
			OCS_BANK_RSVD: begin
				ext_hit_a = 1'b0;
				ext_hit_b = 1'b0;
			end
			default: begin
				ext_hit_a = 1'b0;
				ext_hit_b = 1'b0;
			end
		endcase
	end

	// channel a selection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_a_r <= ocs_sel_t'(`OCS_RST_REG_SEL); // low field of the register default
		end else begin
			if (chan_a_select_source) begin
				if (ext_hit_a) begin
					sel_a_r <= ext_sel_a;
				end
			end else if (!change_blocking_r) begin
				sel_a_r <= reg_sel_a;
			end
		end
	end

	// channel b selection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_b_r <= ocs_sel_t'(`OCS_RST_REG_SEL); // low field of the register default
		end else begin
			if (chan_b_select_source) begin
				if (ext_hit_b) begin
					sel_b_r <= ext_sel_b;
				end
			end else if (!change_blocking_r) begin
				sel_b_r <= reg_sel_b;
			end
		end
	end

	// outputs straight from flops
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign hrdata = hrdata_r;
	assign sel_a = sel_a_r;
	assign sel_b = sel_b_r;
	assign accum_reset = accum_reset_r;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_read_wait;
		!hreadyout_r ##1 hreadyout_r;
	endsequence

	sequence s_armed_sysref;
		arm_r && accum_reset_source == OCS_SYNC_SYSREF && sysref_rise && osc_enable_r;
	endsequence

	a_read_wait_state: assert property (addr_phase && !hwrite |=> s_read_wait)
		else $error("read did not take exactly one wait state");
	a_sync_now_reset: assert property (sync_start && accum_reset_source == OCS_SYNC_NOW
		|=> accum_reset_r)
		else $error("immediate sync gave no accumulator reset");
	a_sysref_arming: assert property (sync_start && accum_reset_source == OCS_SYNC_SYSREF
		&& osc_enable_r |=> arm_r && !accum_reset_r)
		else $error("sysref sync did not arm or reset too early");
	a_sysref_fire: assert property (s_armed_sysref |=> accum_reset_r ##1 !accum_reset_r)
		else $error("armed reset not a single pulse after sysref rise");
	a_trig_bank_gate: assert property (arm_r && accum_reset_source == OCS_SYNC_TRIG
		&& trig_rise && osc_enable_r |=> accum_reset_r == $past(bank_sel))
		else $error("trigger reset not gated by bank line");
	a_rsvd_no_reset: assert property (accum_reset_source == OCS_SYNC_RSVD && osc_enable_r
		&& $past(osc_enable_r) |=> !accum_reset_r && !arm_r)
		else $error("reserved sync source caused a reset");
	a_disable_holds: assert property (!osc_enable_r |=> accum_reset_r)
		else $error("accumulators not held in reset while disabled");
	a_split_bank_b: assert property (trig_rise && chan_b_select_source
		&& osc_bank_config == OCS_BANK_SPLIT |=> sel_b_r == {1'b1, $past(ext_sel)})
		else $error("split bank select wrong for channel b");
	a_shared_bank_a: assert property (trig_rise && chan_a_select_source
		&& osc_bank_config == OCS_BANK_SHARED |=> sel_a_r == {$past(bank_sel), $past(ext_sel)})
		else $error("shared bank select wrong for channel a");
	a_one_chan_hold: assert property (chan_a_select_source && osc_bank_config == OCS_BANK_ONE_CHAN
		&& bank_sel |=> $stable(sel_a_r))
		else $error("channel a changed while bank line chose b");
	a_reg_sel_follow: assert property (!chan_a_select_source && !change_blocking_r
		|=> sel_a_r == $past(reg_sel_a))
		else $error("channel a did not follow its register select");
	a_block_freeze: assert property (!chan_b_select_source && change_blocking_r
		|=> $stable(sel_b_r))
		else $error("channel b select moved while blocked");

endmodule : ocs_top

`default_nettype wire

// ---- core/ocs_regs.svh ----
// register offsets, field positions, reset values and sizes of the accumulator select block
// assumes inclusion by bare name from the package or the design files
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

// register indices; byte address is four times the index
`define OCS_IDX_SYNC_SRC 10'h300
`define OCS_IDX_REG_SEL 10'h301
`define OCS_IDX_BANK_CFG 10'h303
`define OCS_IDX_OSC_EN 10'h308
`define OCS_IDX_SW_SYNC 10'h310
`define OCS_IDX_CHG_BLK 10'h320
`define OCS_IDX_STATUS 10'h3f0

// field positions
`define OCS_SRC_LO 0
`define OCS_SRC_HI 1
`define OCS_CHG_SRC_A_BIT 4
`define OCS_CHG_SRC_B_BIT 5
`define OCS_SEL_A_LO 0
`define OCS_SEL_A_HI 4
`define OCS_SEL_B_LO 8
`define OCS_SEL_B_HI 12
`define OCS_BANK_CFG_LO 0
`define OCS_BANK_CFG_HI 1

// reset values
`define OCS_RST_SYNC_SRC 8'h00
`define OCS_RST_REG_SEL 16'h0000
`define OCS_RST_BANK_CFG 8'h00
`define OCS_RST_1BIT 1'h0

// widths
`define OCS_SEL_W 5
`define OCS_EXT_SEL_W 4

`endif

// ---- core/ocs_pkg.sv ----
// types shared by the accumulator select block
// assumes ocs_regs.svh on the include path
`include "ocs_regs.svh"

package ocs_pkg;

	// accumulator reset trigger source
	typedef enum logic [1:0] {
		OCS_SYNC_NOW,
		OCS_SYNC_SYSREF,
		OCS_SYNC_TRIG,
		OCS_SYNC_RSVD
	} ocs_sync_src_t;

	// how the external select bus maps onto the channels
	typedef enum logic [1:0] {
		OCS_BANK_SPLIT,
		OCS_BANK_SHARED,
		OCS_BANK_ONE_CHAN,
		OCS_BANK_RSVD
	} ocs_bank_cfg_t;

	// accumulator selector: top bit is the bank
	typedef logic [`OCS_SEL_W-1:0] ocs_sel_t;

endpackage : ocs_pkg

// ---- core/ocs_edge_det.sv ----
// rising edge detector for synchronous inputs, one per bit
// assumes inputs already synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none

module ocs_edge_det #(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] rise_out
);

	logic [WIDTH-1:0] prev_r;

	// previous level per bit, with edge taken against it
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					prev_r[gi] <= 1'b0;
				end else begin
					prev_r[gi] <= level_in[gi];
				end
			end
			assign rise_out[gi] = level_in[gi] & ~prev_r[gi];
		end
	endgenerate

endmodule : ocs_edge_det

`default_nettype wire

// ---- bench/ocs_fpga_model.sv ----
// model of the outside logic driving select bus, bank line and trigger
// assumes the bench calls fire right after a rising edge of ref_clk
`timescale 1ns/10ps
`default_nettype none

module ocs_fpga_model (
	input wire logic ref_clk,
	output var logic [3:0] ext_sel,
	output var logic bank_sel,
	output var logic trig
);
	// lines idle low until the first trigger
	initial begin
		ext_sel = 4'h0;
		bank_sel = 1'h0;
		trig = 1'h0;
	end

	// select and bank move on the very edge that raises the trigger
	task automatic fire(input logic [3:0] s, input logic b);
		ext_sel <= s;
		bank_sel <= b;
		trig <= 1'h1;
		@(posedge ref_clk);
		trig <= 1'h0;
		repeat (4) @(posedge ref_clk);
	endtask : fire
endmodule : ocs_fpga_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the accumulator select block
// assumes the one slave's hreadyout is the bus hready
`timescale 1ns/10ps
`default_nettype none
`include "ocs_regs.svh"

module tb;
	import ocs_pkg::*;
	logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, sysref, accum_reset, bank_sel, trig;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] ext_sel;
	ocs_sel_t sel_a, sel_b;
	int miscompares = 0;
	int compares = 0;

	// free running clock
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	ocs_top uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ext_sel(ext_sel), .bank_sel(bank_sel), .trig(trig), .sysref(sysref),
		.sel_a(sel_a), .sel_b(sel_b), .accum_reset(accum_reset));
	ocs_fpga_model fpga (.ref_clk(ref_clk), .ext_sel(ext_sel), .bank_sel(bank_sel), .trig(trig));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// waits for hready sampled high, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'h1 && n < 20) begin
			n++;
			@(posedge ref_clk);
		end
		chk(32'(n < 20), 32'h1);
	endtask : wait_ready

	// one single word transfer, address phase then data phase
	task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		haddr <= {20'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : xfer

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] x;
		xfer(idx, 1'h1, d, x);
	endtask : wr

	task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] x;
		xfer(idx, 1'h0, 32'h0, x);
		chk(x, exp);
		chk(32'(hresp), 32'h0);
	endtask : rdc

	// counts cycles with accum_reset high
	task automatic pulses(input int cycles, input int exp);
		int c;
		c = 0;
		repeat (cycles) begin
			#1;
			if (accum_reset === 1'h1) c++;
			@(posedge ref_clk);
		end
		chk(32'(c), 32'(exp));
	endtask : pulses

	task automatic settle();
		repeat (3) @(posedge ref_clk);
	endtask : settle

	task automatic sync_req();
		wr(`OCS_IDX_SW_SYNC, 32'h0);
		wr(`OCS_IDX_SW_SYNC, 32'h1);
	endtask : sync_req

	task automatic t_reset();
		rdc(`OCS_IDX_SYNC_SRC, 32'h0);
		rdc(`OCS_IDX_REG_SEL, 32'h0);
		rdc(`OCS_IDX_BANK_CFG, 32'h0);
		rdc(`OCS_IDX_STATUS, 32'h0001_0000);
		rdc(10'h3ff, 32'h0);
		pulses(4, 4);
	endtask : t_reset

	task automatic t_regsel();
		wr(`OCS_IDX_REG_SEL, 32'h0000_f2f5);
		rdc(`OCS_IDX_REG_SEL, 32'h0000_f2f5);
		wr(`OCS_IDX_OSC_EN, 32'h1);
		settle();
		pulses(3, 0);
		chk(32'(sel_a), 32'h15);
		chk(32'(sel_b), 32'h12);
		wr(`OCS_IDX_CHG_BLK, 32'h1);
		wr(`OCS_IDX_REG_SEL, 32'h0304);
		settle();
		chk(32'(sel_a), 32'h15);
		wr(`OCS_IDX_CHG_BLK, 32'h0);
		settle();
		chk({sel_b, 3'h0, sel_a}, 32'h0304);
	endtask : t_regsel

	task automatic t_sync();
		wr(`OCS_IDX_SYNC_SRC, 32'h0);
		sync_req();
		pulses(4, 1);
		wr(`OCS_IDX_SW_SYNC, 32'h1);
		pulses(4, 0);
		rdc(`OCS_IDX_SW_SYNC, 32'h1);
		wr(`OCS_IDX_SYNC_SRC, 32'h1);
		sync_req();
		pulses(6, 0);
		rdc(`OCS_IDX_STATUS, 32'h0002_0304);
		sysref <= 1'h1;
		pulses(5, 1);
		sysref <= 1'h0;
		wr(`OCS_IDX_SYNC_SRC, 32'h2);
		sync_req();
		fork fpga.fire(4'h5, 1'h0); pulses(6, 0); join
		fork fpga.fire(4'h5, 1'h1); pulses(6, 1); join
		wr(`OCS_IDX_SYNC_SRC, 32'h3);
		sync_req();
		sysref <= 1'h1;
		fork fpga.fire(4'h0, 1'h1); pulses(6, 0); join
		sysref <= 1'h0;
	endtask : t_sync

	task automatic ext_case(input logic [1:0] cfg, input logic [3:0] s, input logic b, input ocs_sel_t ea,
		input ocs_sel_t eb);
		wr(`OCS_IDX_CHG_BLK, 32'h1);
		wr(`OCS_IDX_BANK_CFG, 32'(cfg));
		wr(`OCS_IDX_CHG_BLK, 32'h0);
		fpga.fire(s, b);
		chk({sel_b, 3'h0, sel_a}, {19'h0, eb, 3'h0, ea});
	endtask : ext_case

	task automatic t_ext();
		wr(`OCS_IDX_CHG_BLK, 32'h1);
		wr(`OCS_IDX_SYNC_SRC, 32'h20);
		wr(`OCS_IDX_REG_SEL, 32'h0001);
		ext_case(2'h0, 4'h4, 1'h0, 5'h01, 5'h14);
		wr(`OCS_IDX_SYNC_SRC, 32'h30);
		ext_case(2'h0, 4'h9, 1'h1, 5'h09, 5'h19);
		ext_case(2'h1, 4'h3, 1'h1, 5'h13, 5'h13);
		ext_case(2'h2, 4'h7, 1'h0, 5'h07, 5'h13);
		ext_case(2'h2, 4'h2, 1'h1, 5'h07, 5'h12);
		ext_case(2'h3, 4'hc, 1'h1, 5'h07, 5'h12);
	endtask : t_ext

	task automatic report_and_stop();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	// watchdog against a hung handshake
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end

	// main sequence
	initial begin
		rst = 1'h1;
		hsel = 1'h1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sysref = 1'h0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		t_reset();
		t_regsel();
		t_sync();
		t_ext();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
